// ===== include/tmr_pkg.sv
// constants shared by the timer unit: register map, fields, reset values
// assumes a 32-bit ahb-lite slave, one word per register
package tmr_pkg;
    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_PRESCALER = 8'h00;
    localparam logic [7:0] OFF_FIRST_TIMER = 8'h04;
    localparam logic [7:0] OFF_SECOND_TIMER = 8'h08;
    localparam logic [7:0] OFF_WIDE_UPPER = 8'h0C;
    localparam logic [7:0] OFF_WIDE_LOWER = 8'h10;
    localparam logic [7:0] OFF_MODE = 8'h14;
    localparam logic [7:0] OFF_REQUEST = 8'h18;
    localparam logic [7:0] OFF_CMP_POINTER = 8'h1C;
    localparam logic [7:0] OFF_CMP_LOW = 8'h20;
    localparam logic [7:0] OFF_CMP_HIGH = 8'h24;
    localparam logic [7:0] OFF_CMP_RELOAD = 8'h28;
    localparam logic [7:0] OFF_CMP_CONTROL = 8'h2C;
    localparam logic [7:0] OFF_CMP_STATUS = 8'h30;
    localparam logic [7:0] OFF_CMP_INT_SOURCE = 8'h34;
    // ------------------------------------------------------------------
    // mode register fields
    // ------------------------------------------------------------------
    localparam int MODE_PRE_SRC = 0;
    localparam int MODE_T2_SRC_LO = 1;
    localparam int MODE_T2_WRITE_LATCH = 3;
    localparam int MODE_T2_STOP = 4;
    localparam int MODE_TOGGLE_VALID = 5;
    localparam int MODE_TOGGLE_POL = 6;
    localparam int MODE_WIDE_SRC_LO = 8;
    localparam int MODE_WIDE_WRITE_LATCH = 11;
    localparam int MODE_WIDE_STOP = 12;
    localparam int MODE_WIDTH = 13;
    // ------------------------------------------------------------------
    // compare control fields: [2:0] port sel, [5:3] trig en, [8:6] level
    // ------------------------------------------------------------------
    localparam int CTL_PORT_LO = 0;
    localparam int CTL_TRIG_LO = 3;
    localparam int CTL_LEVEL_LO = 6;
    localparam int CTL_WIDTH = 9;
    // request bits
    localparam int REQ_FIRST = 0;
    localparam int REQ_SECOND = 1;
    localparam int REQ_WIDE = 2;
    localparam int REQ_WIDTH = 3;
    // ------------------------------------------------------------------
    // reset values and dividers
    // ------------------------------------------------------------------
    localparam logic [7:0] PRE_RESET = 8'hFF;
    localparam logic [7:0] FIRST_RESET = 8'h01;
    localparam logic [7:0] SECOND_RESET = 8'hFF;
    localparam logic [15:0] WIDE_RESET = 16'hFFFF;
    localparam int DIV_BITS = 8;
    localparam int CHANNELS = 3;
    localparam int LATCHES = 6;
    typedef enum logic [2:0] {
        WSRC_DIV2 = 3'b000,
        WSRC_DIV16 = 3'b001,
        WSRC_DIV32 = 3'b010,
        WSRC_DIV64 = 3'b011,
        WSRC_DIV128 = 3'b100,
        WSRC_DIV256 = 3'b101,
        WSRC_LOW_OSC = 3'b110,
        WSRC_SUB_OSC = 3'b111
    } wide_src_t;
    typedef enum logic [1:0] {
        T2SRC_DIV16 = 2'b00,
        T2SRC_DIV256 = 2'b01,
        T2SRC_PRESCALER = 2'b10,
        T2SRC_WIDE = 2'b11
    } second_src_t;
endpackage

// ===== hw/timer_unit.sv
// timer unit: prescaler, two byte timers, wide timer, three compare channels
// assumes one 20 MHz clock; oscillator ticks arrive as synchronous pulses
//
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps

// Functional notes
// - counters decrement per pulse, reload from latch after zero, ratio 1/(n+1)
// - underflow of first, second or wide timer sets its request bit
// - 8-bit prescaler counts clock/16 or sub oscillator per select bit
// - prescaler write loads latch and counter; read gives count; reset FF
// - prescaler and first timer always run, software cannot stop them
// - first timer counts prescaler output; write loads both; reset 01
// - second timer source: clock/16, clock/256, prescaler, wide underflow
// - second timer write loads both or latch only per write control
// - second timer starts at FF and holds while stop bit set
// - toggle pin inverts per second timer underflow; polarity sets start
// - wide timer source: clock/2..256, low oscillator or sub oscillator
// - latch-only write mode updates latch only, even while stopped
// - wide timer starts at FFFF and holds while stop bit set
// - three compare channels on wide count, pin driven when selected
// - reload bit copies value at next wide underflow then self-clears
// - trigger on: x0 match drives high, x1 low; level latch swaps
// - trigger off holds pin, matches still raise compare requests
// - match raises request if source bit set; status shows level
// - stopped timer: compare write direct; trigger enable inits output
// - latch above reload value never matches
module timer_unit #(
    parameter int PRE_WIDTH = 8
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // oscillator tick pulses
    input wire logic sub_oscillator_input,
    input wire logic low_osc_tick,
    // pins
    output logic port1_bit3,
    output logic [2:0] compare_out,
    output logic [2:0] compare_oe_n,
    // event pulses
    output logic [5:0] compare_irq
);
    // ------------------------------------------------------------------
    // bus address phase
    // ------------------------------------------------------------------
    logic wr_pend, rd_pend;
    logic [7:0] addr_q;
    wire take = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_pend <= take && hwrite;
            rd_pend <= take && !hwrite;
            if (take) begin
                addr_q <= haddr[7:0];
            end
        end
    end
    wire rd_take = take && !hwrite;
    wire [7:0] rd_addr = haddr[7:0];
    wire w_pre = wr_pend && addr_q == tmr_pkg::OFF_PRESCALER;
    wire w_first = wr_pend && addr_q == tmr_pkg::OFF_FIRST_TIMER;
    wire w_second = wr_pend && addr_q == tmr_pkg::OFF_SECOND_TIMER;
    wire w_upper = wr_pend && addr_q == tmr_pkg::OFF_WIDE_UPPER;
    wire w_lower = wr_pend && addr_q == tmr_pkg::OFF_WIDE_LOWER;
    wire w_mode = wr_pend && addr_q == tmr_pkg::OFF_MODE;
    wire w_req = wr_pend && addr_q == tmr_pkg::OFF_REQUEST;
    wire w_ptr = wr_pend && addr_q == tmr_pkg::OFF_CMP_POINTER;
    wire w_clo = wr_pend && addr_q == tmr_pkg::OFF_CMP_LOW;
    wire w_chi = wr_pend && addr_q == tmr_pkg::OFF_CMP_HIGH;
    wire w_rld = wr_pend && addr_q == tmr_pkg::OFF_CMP_RELOAD;
    wire w_ctl = wr_pend && addr_q == tmr_pkg::OFF_CMP_CONTROL;
    wire w_isrc = wr_pend && addr_q == tmr_pkg::OFF_CMP_INT_SOURCE;
    wire [7:0] wb = hwdata[7:0];

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    logic [tmr_pkg::MODE_WIDTH-1:0] mode;
    logic [tmr_pkg::CTL_WIDTH-1:0] cmp_ctl;
    logic [2:0] cmp_ptr;
    logic [5:0] int_src;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode <= '0;
            cmp_ptr <= 3'h0;
            int_src <= 6'h00;
        end else begin
            if (w_mode) mode <= hwdata[tmr_pkg::MODE_WIDTH-1:0];
            if (w_ptr) cmp_ptr <= hwdata[2:0];
            if (w_isrc) int_src <= hwdata[5:0];
        end
    end
    wire pre_src_sub = mode[tmr_pkg::MODE_PRE_SRC];
    wire [1:0] t2_src = mode[tmr_pkg::MODE_T2_SRC_LO +: 2];
    wire t2_latch_only = mode[tmr_pkg::MODE_T2_WRITE_LATCH];
    wire t2_stop = mode[tmr_pkg::MODE_T2_STOP];
    wire tog_valid = mode[tmr_pkg::MODE_TOGGLE_VALID];
    wire tog_pol = mode[tmr_pkg::MODE_TOGGLE_POL];
    wire [2:0] wide_src = mode[tmr_pkg::MODE_WIDE_SRC_LO +: 3];
    wire wide_latch_only = mode[tmr_pkg::MODE_WIDE_WRITE_LATCH];
    wire wide_stop = mode[tmr_pkg::MODE_WIDE_STOP];

    // ------------------------------------------------------------------
    // system clock divider taps
    // ------------------------------------------------------------------
    logic [tmr_pkg::DIV_BITS-1:0] div;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) div <= '0;
        else div <= div + 1'b1;
    end
    // tap k pulses once every 2^k cycles
    wire [tmr_pkg::DIV_BITS:1] tap;
    genvar k;
    generate
        for (k = 1; k <= tmr_pkg::DIV_BITS; k++) begin : g_tap
            assign tap[k] = &div[k-1:0];
        end
    endgenerate

    // ------------------------------------------------------------------
    // prescaler and first timer
    // ------------------------------------------------------------------
    logic [PRE_WIDTH-1:0] pre_cnt, pre_latch;
    logic [7:0] t1_cnt, t1_latch, t2_cnt, t2_latch;
    logic [15:0] wide_cnt, wide_latch;
    wire pre_tick = pre_src_sub ? sub_oscillator_input : tap[4];
    wire pre_uf = pre_tick && pre_cnt == '0;
    wire t1_uf = pre_uf && t1_cnt == 8'h00;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_cnt <= PRE_WIDTH'(tmr_pkg::PRE_RESET);
            pre_latch <= PRE_WIDTH'(tmr_pkg::PRE_RESET);
        end else if (w_pre) begin
            pre_cnt <= PRE_WIDTH'(wb);
            pre_latch <= PRE_WIDTH'(wb);
        end else if (pre_tick) begin
            pre_cnt <= pre_uf ? pre_latch : pre_cnt - 1'b1;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            t1_cnt <= tmr_pkg::FIRST_RESET;
            t1_latch <= tmr_pkg::FIRST_RESET;
        end else if (w_first) begin
            t1_cnt <= wb;
            t1_latch <= wb;
        end else if (pre_uf) begin
            t1_cnt <= t1_uf ? t1_latch : t1_cnt - 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // wide timer
    // ------------------------------------------------------------------
    logic wide_tick;
    always_comb begin
        case (tmr_pkg::wide_src_t'(wide_src))
            tmr_pkg::WSRC_DIV2: wide_tick = tap[1];
            tmr_pkg::WSRC_DIV16: wide_tick = tap[4];
            tmr_pkg::WSRC_DIV32: wide_tick = tap[5];
            tmr_pkg::WSRC_DIV64: wide_tick = tap[6];
            tmr_pkg::WSRC_DIV128: wide_tick = tap[7];
            tmr_pkg::WSRC_DIV256: wide_tick = tap[8];
            tmr_pkg::WSRC_LOW_OSC: wide_tick = low_osc_tick;
            tmr_pkg::WSRC_SUB_OSC: wide_tick = sub_oscillator_input;
            default: wide_tick = 1'b0;
        endcase
    end
    wire wide_run = wide_tick && !wide_stop;
    wire wide_uf = wide_run && wide_cnt == 16'h0000;
    logic [7:0] lower_buf, lower_snap;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lower_buf <= 8'h00;
            lower_snap <= 8'h00;
        end else begin
            if (w_lower) lower_buf <= wb;
            if (rd_take && rd_addr == tmr_pkg::OFF_WIDE_UPPER) begin
                lower_snap <= wide_cnt[7:0];
            end
        end
    end
    wire [15:0] wide_wval = {wb, lower_buf};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wide_cnt <= tmr_pkg::WIDE_RESET;
            wide_latch <= tmr_pkg::WIDE_RESET;
        end else if (w_upper) begin
            wide_latch <= wide_wval;
            if (!wide_latch_only) wide_cnt <= wide_wval;
        end else if (wide_run) begin
            wide_cnt <= wide_uf ? wide_latch : wide_cnt - 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // second timer and toggle pin
    // ------------------------------------------------------------------
    logic t2_tick;
    always_comb begin
        case (tmr_pkg::second_src_t'(t2_src))
            tmr_pkg::T2SRC_DIV16: t2_tick = tap[4];
            tmr_pkg::T2SRC_DIV256: t2_tick = tap[8];
            tmr_pkg::T2SRC_PRESCALER: t2_tick = pre_uf;
            tmr_pkg::T2SRC_WIDE: t2_tick = wide_uf;
            default: t2_tick = 1'b0;
        endcase
    end
    wire t2_run = t2_tick && !t2_stop;
    wire t2_uf = t2_run && t2_cnt == 8'h00;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            t2_cnt <= tmr_pkg::SECOND_RESET;
            t2_latch <= tmr_pkg::SECOND_RESET;
        end else if (w_second) begin
            t2_latch <= wb;
            if (!t2_latch_only) t2_cnt <= wb;
        end else if (t2_run) begin
            t2_cnt <= t2_uf ? t2_latch : t2_cnt - 8'h01;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) port1_bit3 <= 1'b1;
        else if (!tog_valid) port1_bit3 <= !tog_pol;
        else if (t2_uf) port1_bit3 <= !port1_bit3;
    end

    // ------------------------------------------------------------------
    // interrupt request bits: set wins over software clear
    // ------------------------------------------------------------------
    logic [tmr_pkg::REQ_WIDTH-1:0] req;
    wire [tmr_pkg::REQ_WIDTH-1:0] req_set = {wide_uf, t2_uf, t1_uf};
    wire [tmr_pkg::REQ_WIDTH-1:0] req_clr =
        w_req ? ~hwdata[tmr_pkg::REQ_WIDTH-1:0] : '0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) req <= '0;
        else req <= (req & ~req_clr) | req_set;
    end

    // ------------------------------------------------------------------
    // compare channels
    // ------------------------------------------------------------------
    logic [15:0] cmp_reg;
    logic [15:0] cmp_latch [tmr_pkg::LATCHES];
    logic [15:0] cmp_pend [tmr_pkg::LATCHES];
    logic [5:0] reload;
    logic [2:0] level;
    wire [5:0] match;
    wire [2:0] trig_en = cmp_ctl[tmr_pkg::CTL_TRIG_LO +: 3];
    wire [2:0] lvl_latch = cmp_ctl[tmr_pkg::CTL_LEVEL_LO +: 3];
    wire [2:0] port_sel = cmp_ctl[tmr_pkg::CTL_PORT_LO +: 3];
    wire [2:0] trig_rise =
        w_ctl ? hwdata[tmr_pkg::CTL_TRIG_LO +: 3] & ~trig_en : 3'h0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) cmp_reg <= 16'h0000;
        else if (w_clo) cmp_reg[7:0] <= wb;
        else if (w_chi) cmp_reg[15:8] <= wb;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) cmp_ctl <= '0;
        else if (w_ctl) cmp_ctl <= hwdata[tmr_pkg::CTL_WIDTH-1:0];
    end
    generate
        for (k = 0; k < tmr_pkg::LATCHES; k++) begin : g_latch
            wire sel = cmp_ptr == 3'(k);
            // value above reload never reached by the down count
            assign match[k] = wide_run && wide_cnt == cmp_latch[k] &&
                cmp_latch[k] <= wide_latch;
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cmp_latch[k] <= 16'h0000;
                    cmp_pend[k] <= 16'h0000;
                    reload[k] <= 1'b0;
                end else begin
                    if (sel && (w_clo || w_chi)) begin
                        cmp_pend[k] <= w_clo ? {cmp_reg[15:8], wb}
                                             : {wb, cmp_reg[7:0]};
                        if (wide_stop) begin
                            cmp_latch[k] <= w_clo ? {cmp_reg[15:8], wb}
                                                  : {wb, cmp_reg[7:0]};
                        end
                    end
                    if (w_rld && hwdata[k]) reload[k] <= 1'b1;
                    else if (wide_uf && reload[k]) begin
                        cmp_latch[k] <= cmp_pend[k];
                        reload[k] <= 1'b0;
                    end
                end
            end
        end
        for (k = 0; k < tmr_pkg::CHANNELS; k++) begin : g_chan
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    level[k] <= 1'b0;
                end else if (trig_rise[k] && wide_stop) begin
                    level[k] <= hwdata[tmr_pkg::CTL_LEVEL_LO + k];
                end else if (trig_en[k]) begin
                    if (match[2*k]) level[k] <= !lvl_latch[k];
                    else if (match[2*k+1]) level[k] <= lvl_latch[k];
                end
            end
        end
    endgenerate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_out <= 3'h0;
            compare_oe_n <= 3'h7;
            compare_irq <= 6'h00;
        end else begin
            compare_out <= level;
            compare_oe_n <= ~port_sel;
            compare_irq <= match & int_src;
        end
    end

    // ------------------------------------------------------------------
    // read data and response
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        case (rd_addr)
            tmr_pkg::OFF_PRESCALER: rd_mux = 32'(pre_cnt);
            tmr_pkg::OFF_FIRST_TIMER: rd_mux = {24'h0, t1_cnt};
            tmr_pkg::OFF_SECOND_TIMER: rd_mux = {24'h0, t2_cnt};
            tmr_pkg::OFF_WIDE_UPPER: rd_mux = {24'h0, wide_cnt[15:8]};
            tmr_pkg::OFF_WIDE_LOWER: rd_mux = {24'h0, lower_snap};
            tmr_pkg::OFF_MODE: rd_mux = 32'(mode);
            tmr_pkg::OFF_REQUEST: rd_mux = 32'(req);
            tmr_pkg::OFF_CMP_POINTER: rd_mux = {29'h0, cmp_ptr};
            tmr_pkg::OFF_CMP_LOW: rd_mux = {24'h0, cmp_reg[7:0]};
            tmr_pkg::OFF_CMP_HIGH: rd_mux = {24'h0, cmp_reg[15:8]};
            tmr_pkg::OFF_CMP_RELOAD: rd_mux = {26'h0, reload};
            tmr_pkg::OFF_CMP_CONTROL: rd_mux = 32'(cmp_ctl);
            tmr_pkg::OFF_CMP_STATUS: rd_mux = {29'h0, level};
            tmr_pkg::OFF_CMP_INT_SOURCE: rd_mux = {26'h0, int_src};
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) hrdata <= 32'h0000_0000;
        else if (rd_take) hrdata <= rd_mux;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_pre_reload: assert property (@(posedge hclk) disable iff (!hresetn)
        pre_uf && !w_pre |=> pre_cnt == $past(pre_latch))
        else $error("prescaler missed reload");
    a_req_set: assert property (@(posedge hclk) disable iff (!hresetn)
        t1_uf |=> req[tmr_pkg::REQ_FIRST])
        else $error("first timer request not set");
    a_wide_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        wide_stop && !w_upper |=> $stable(wide_cnt))
        else $error("wide timer moved while stopped");
    a_second_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        t2_stop && !w_second |=> $stable(t2_cnt))
        else $error("second timer moved while stopped");
    a_latch_only: assert property (@(posedge hclk) disable iff (!hresetn)
        w_upper && wide_latch_only && !wide_run |=> $stable(wide_cnt))
        else $error("latch-only write changed count");
    a_toggle_flip: assert property (@(posedge hclk) disable iff (!hresetn)
        tog_valid && t2_uf |=> port1_bit3 != $past(port1_bit3))
        else $error("toggle pin did not invert");
    a_reload_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        wide_uf && reload[0] && !w_rld |=> !reload[0] &&
        cmp_latch[0] == $past(cmp_pend[0]))
        else $error("compare reload failed");
    a_trig_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !trig_en[0] && !w_ctl |=> $stable(level[0]))
        else $error("level moved with trigger off");
    a_match_high: assert property (@(posedge hclk) disable iff (!hresetn)
        trig_en[0] && !lvl_latch[0] && match[0] && !w_ctl
        |=> level[0])
        else $error("x0 match did not drive high");
    a_irq_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
        match[1] && int_src[1] |=> compare_irq[1])
        else $error("compare request missing");
endmodule // timer_unit

// ===== tb/timer_unit_bench.sv
// bench for the timer unit: integer model of counters, pins and requests
// assumes timer_unit answers ahb-lite with zero wait states
`timescale 1ns/1ps
module timer_unit_bench;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sub = 0, low = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, seed = 32'h5B824BD7;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2, c_out, c_oe_n;
    logic [5:0] irq;
    logic hreadyout, hresp, pin;
    int bad_count = 0, total_checks = 0, cyc = 0;
    int p, f, v, w, mp, m1, m2, req, tog, st;
    timer_unit u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sub_oscillator_input(sub),
        .low_osc_tick(low), .port1_bit3(pin), .compare_out(c_out),
        .compare_oe_n(c_oe_n), .compare_irq(irq));
    initial begin
        forever #25 hclk = ~hclk;
    end
    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input int d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= 32'(d);
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // one sub clock pulse, model advanced alongside
    task automatic tick();
        sub <= 1'b1;
        @(posedge hclk);
        sub <= 1'b0;
        @(posedge hclk);
        if (mp == 0 && m1 == 0) req |= 1;
        if (mp == 0 && m2 == 0 && st == 0) begin
            req |= 2;
            tog ^= 1;
        end
        if (mp == 0) m1 = (m1 == 0) ? f : m1 - 1;
        if (mp == 0 && st == 0) m2 = (m2 == 0) ? w : m2 - 1;
        mp = (mp == 0) ? p : mp - 1;
    endtask
    task automatic irq_pin(input int b, input logic e);
        int n;
        n = 0;
        while (irq[b] !== 1'b1 && n < 300) begin
            @(posedge hclk);
            n++;
        end
        repeat (2) @(posedge hclk);
        chk({29'h0, c_out}, {31'h0, e});
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            end_sim();
        end
    end
    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(0, 8'h3C, 0);
        chk(rd, 0);
        chk({31'h0, pin}, 1);
        bus(1, tmr_pkg::OFF_MODE, 32'h1715);
        p = int'(rnd() & 32'h3);
        f = int'(rnd() & 32'h3);
        v = int'(rnd() & 32'h7);
        w = int'(rnd() & 32'h7);
        bus(1, tmr_pkg::OFF_PRESCALER, p);
        bus(0, tmr_pkg::OFF_PRESCALER, 0);
        chk(rd, 32'(p));
        bus(1, tmr_pkg::OFF_FIRST_TIMER, f);
        bus(0, tmr_pkg::OFF_FIRST_TIMER, 0);
        chk(rd, 32'(f));
        bus(1, tmr_pkg::OFF_SECOND_TIMER, v);
        mp = p;
        m1 = f;
        m2 = v;
        req = 0;
        tog = 0;
        st = 1;
        repeat (6) tick();
        bus(0, tmr_pkg::OFF_SECOND_TIMER, 0);
        chk(rd, 32'(m2));
        bus(1, tmr_pkg::OFF_MODE, 32'h172D);
        st = 0;
        bus(1, tmr_pkg::OFF_SECOND_TIMER, w);
        bus(0, tmr_pkg::OFF_SECOND_TIMER, 0);
        chk(rd, 32'(m2));
        repeat (40) tick();
        bus(0, tmr_pkg::OFF_PRESCALER, 0);
        chk(rd, 32'(mp));
        bus(0, tmr_pkg::OFF_FIRST_TIMER, 0);
        chk(rd, 32'(m1));
        bus(0, tmr_pkg::OFF_SECOND_TIMER, 0);
        chk(rd, 32'(m2));
        bus(0, tmr_pkg::OFF_REQUEST, 0);
        chk(rd, 32'(req));
        chk({31'h0, pin}, 32'(tog ^ 1));
        bus(1, tmr_pkg::OFF_REQUEST, 0);
        bus(0, tmr_pkg::OFF_REQUEST, 0);
        chk(rd, 0);
        $display("test counters done");
        bus(1, tmr_pkg::OFF_WIDE_LOWER, 32'h10);
        bus(1, tmr_pkg::OFF_WIDE_UPPER, 0);
        bus(0, tmr_pkg::OFF_WIDE_UPPER, 0);
        chk(rd, 0);
        bus(0, tmr_pkg::OFF_WIDE_LOWER, 0);
        chk(rd, 32'h10);
        bus(1, tmr_pkg::OFF_CMP_POINTER, 1);
        bus(1, tmr_pkg::OFF_CMP_LOW, 32'h0A);
        bus(1, tmr_pkg::OFF_CMP_HIGH, 0);
        bus(1, tmr_pkg::OFF_CMP_POINTER, 0);
        bus(1, tmr_pkg::OFF_CMP_HIGH, 0);
        bus(1, tmr_pkg::OFF_CMP_LOW, 32'h05);
        bus(1, tmr_pkg::OFF_CMP_INT_SOURCE, 32'h3);
        bus(1, tmr_pkg::OFF_CMP_CONTROL, 32'h9);
        repeat (2) @(posedge hclk);
        chk({29'h0, c_oe_n}, 32'h6);
        chk({31'h0, hresp}, 0);
        bus(1, tmr_pkg::OFF_MODE, 32'h0011);
        irq_pin(1, 1'b0);
        irq_pin(0, 1'b1);
        bus(0, tmr_pkg::OFF_CMP_STATUS, 0);
        chk(rd, 1);
        irq_pin(1, 1'b0);
        bus(1, tmr_pkg::OFF_CMP_POINTER, 0);
        bus(1, tmr_pkg::OFF_CMP_LOW, 32'h05);
        bus(1, tmr_pkg::OFF_CMP_HIGH, 0);
        bus(1, tmr_pkg::OFF_CMP_RELOAD, 1);
        bus(0, tmr_pkg::OFF_CMP_RELOAD, 0);
        chk(rd, 1);
        repeat (40) @(posedge hclk);
        bus(0, tmr_pkg::OFF_CMP_RELOAD, 0);
        chk(rd, 0);
        $display("test compare done");
        bus(1, tmr_pkg::OFF_MODE, 32'h1000);
        bus(1, tmr_pkg::OFF_WIDE_LOWER, 32'h34);
        bus(1, tmr_pkg::OFF_WIDE_UPPER, 32'h12);
        bus(1, tmr_pkg::OFF_MODE, 32'h1800);
        bus(1, tmr_pkg::OFF_WIDE_LOWER, 32'h33);
        bus(1, tmr_pkg::OFF_WIDE_UPPER, 32'h44);
        bus(0, tmr_pkg::OFF_WIDE_UPPER, 0);
        chk(rd, 32'h12);
        bus(0, tmr_pkg::OFF_WIDE_LOWER, 0);
        chk(rd, 32'h34);
        $display("test latch done");
        end_sim();
    end
endmodule // timer_unit_bench
